//--- core/dab_pkg.sv
// Overview of operation
// - delay and converter registers take reads and writes at any moment
// - burst gate delay is eight bits, resets to 0x5d, bit 0 is lsb
// - converter register resets to 0x82: clamp code two, chroma asleep
// - clamp field bits 7:6 picks back-porch level 0x30, 0x34, 0x38, 0x3c
// - sync threshold bit clear gives high threshold, set gives low
// - clock sleep stops system clock; bus and output clocks keep going
// - luma sleep bit set puts luma converter to sleep
// - chroma sleep bit set sleeps chroma converter; absent variants ignore it
// - reads of 0x1b through 0x1e return fixed filler 0x00
// - any write to 0x1f restores every control register default
// - reads of 0x1f return fixed filler 0x00 and reset nothing
`default_nettype none
package dab_pkg;
  localparam logic [7:0] DAB_OFS_BURST   = 8'h19;
  localparam logic [7:0] DAB_OFS_CONV    = 8'h1a;
  localparam logic [7:0] DAB_OFS_RSV_LO  = 8'h1b;
  localparam logic [7:0] DAB_OFS_RSV_HI  = 8'h1e;
  localparam logic [7:0] DAB_OFS_SOFTWARE_RESET_CMD  = 8'h1f;
  localparam logic [7:0] DAB_RST_BURST   = 8'h5d;
  localparam logic [7:0] DAB_RST_CONV    = 8'h82;
  localparam logic [7:0] DAB_RSV_READ    = 8'h00;
  localparam int         DAB_POS_CLAMP   = 6;
  localparam int         DAB_POS_SYNC    = 5;
  localparam int         DAB_POS_GAIN    = 4;
  localparam int         DAB_POS_CLK     = 3;
  localparam int         DAB_POS_LUMA    = 2;
  localparam int         DAB_POS_CHROMA  = 1;
  localparam logic [7:0] DAB_CLAMP_L0    = 8'h30;
  localparam logic [7:0] DAB_CLAMP_L1    = 8'h34;
  localparam logic [7:0] DAB_CLAMP_L2    = 8'h38;
  localparam logic [7:0] DAB_CLAMP_L3    = 8'h3c;
  typedef struct packed {
    logic [1:0] clamp;
    logic       sync_low;
    logic       gain_control_disable;
    logic       clk_sleep;
    logic       luma_sleep;
    logic       chroma_sleep;
    logic       rsvd;
  } dab_conv_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dab_req_t;
  typedef struct packed {
    logic [7:0] clamp_level;
    logic       sync_low;
    logic       gain_control_disable;
    logic       clk_sleep;
    logic       luma_sleep;
    logic       chroma_sleep;
    logic [7:0] burst_gate_delay;
  } dab_ctrl_t;
endpackage
`default_nettype wire

//--- core/dab_regs.sv
`default_nettype none
module dab_regs
  import dab_pkg::*;
#(
  parameter bit HAS_CHROMA = 1'b1
)(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire dab_req_t   req,
  output var  logic [7:0] rdata,
  output var  logic       rvalid,
  output var  dab_ctrl_t  ctrl,
  output var  logic       soft_reset_pulse
);
  logic [7:0] burst_reg;
  dab_conv_t  conv_reg;
  dab_conv_t  conv_next;
  logic       wr_burst;
  logic       wr_conv;
  logic       wr_software_reset_cmd;

  function automatic logic [7:0] clamp_level(input logic [1:0] code);
    unique case (code)
      2'b00: clamp_level = DAB_CLAMP_L0;
      2'b01: clamp_level = DAB_CLAMP_L1;
      2'b10: clamp_level = DAB_CLAMP_L2;
      2'b11: clamp_level = DAB_CLAMP_L3;
    endcase
  endfunction

  // write decode, no timing qualifier
  // always accessible
  assign wr_burst  = req.wr && (req.addr == DAB_OFS_BURST);
  assign wr_conv   = req.wr && (req.addr == DAB_OFS_CONV);
  assign wr_software_reset_cmd = req.wr && (req.addr == DAB_OFS_SOFTWARE_RESET_CMD);

  always_comb
  begin
    conv_next = dab_conv_t'(req.wdata);
    if (!HAS_CHROMA)
    begin
      conv_next.chroma_sleep = conv_reg.chroma_sleep;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      burst_reg <= DAB_RST_BURST;
    else if (wr_software_reset_cmd)
      burst_reg <= DAB_RST_BURST;
    else if (wr_burst)
      burst_reg <= req.wdata;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      conv_reg <= dab_conv_t'(DAB_RST_CONV);
    else if (wr_software_reset_cmd)
      conv_reg <= dab_conv_t'(DAB_RST_CONV);
    else if (wr_conv)
      conv_reg <= conv_next;
  end

  // read path; reserved and reset address give fixed filler
  // reserved reads defined as filler
  // reset address read has no effect
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      if (req.addr == DAB_OFS_BURST)
        rdata <= burst_reg;
      else if (req.addr == DAB_OFS_CONV)
        rdata <= HAS_CHROMA ? 8'(conv_reg)
                            : (8'(conv_reg) & ~(8'h01 << DAB_POS_CHROMA));
      else
        rdata <= DAB_RSV_READ;
    end
  end

  // control outputs toward the decoder datapath
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= '{clamp_level: DAB_CLAMP_L2, sync_low: 1'b0, gain_control_disable: 1'b0,
                clk_sleep: 1'b0, luma_sleep: 1'b0, chroma_sleep: 1'b1,
                burst_gate_delay: DAB_RST_BURST};
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      ctrl.clamp_level          <= clamp_level(conv_reg.clamp);
      ctrl.sync_low             <= conv_reg.sync_low;
      ctrl.gain_control_disable <= conv_reg.gain_control_disable;
      ctrl.clk_sleep            <= conv_reg.clk_sleep;
      ctrl.luma_sleep           <= conv_reg.luma_sleep;
      ctrl.chroma_sleep         <= conv_reg.chroma_sleep && HAS_CHROMA;
      ctrl.burst_gate_delay     <= burst_reg;
      soft_reset_pulse          <= wr_software_reset_cmd;
    end
  end

  // write to reset address restores defaults
  software_reset_cmd_defaults_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_software_reset_cmd |=> (burst_reg == DAB_RST_BURST) && (8'(conv_reg) == DAB_RST_CONV)
    && soft_reset_pulse) else $error("soft reset did not restore defaults");
  burst_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_burst && !wr_software_reset_cmd |=> burst_reg == $past(req.wdata)) else $error("burst write lost");
  burst_out_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr_burst |=> ##1 ctrl.burst_gate_delay == $past(req.wdata, 2))
    else $error("burst delay not driven");
  sequence conv_wr_s;
    wr_conv ##1 1'b1;
  endsequence
  clamp_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.clamp_level == clamp_level($past(req.wdata[7:6], 2)))
    else $error("clamp level mismatch");
  sync_thresh_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.sync_low == $past(req.wdata[DAB_POS_SYNC], 2))
    else $error("sync threshold mismatch");
  gain_ctrl_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.gain_control_disable == $past(req.wdata[DAB_POS_GAIN], 2))
    else $error("gain control mismatch");
  clk_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.clk_sleep == $past(req.wdata[DAB_POS_CLK], 2))
    else $error("clock sleep mismatch");
  luma_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.luma_sleep == $past(req.wdata[DAB_POS_LUMA], 2))
    else $error("luma sleep mismatch");
  chroma_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
    conv_wr_s |=> ctrl.chroma_sleep == (HAS_CHROMA && $past(req.wdata[DAB_POS_CHROMA], 2)))
    else $error("chroma sleep mismatch");
  software_reset_cmd_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    req.rd && !req.wr && req.addr == DAB_OFS_SOFTWARE_RESET_CMD |=> !soft_reset_pulse)
    else $error("read caused reset");
endmodule
`default_nettype wire

//--- bench/dab_host.sv
`default_nettype none
module dab_host
  import dab_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output var  dab_req_t   req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic v);
    logic wok;
    wok = w && !(a >= DAB_OFS_RSV_LO && a <= DAB_OFS_RSV_HI);
    @(posedge clock);
    req <= '{wok, r, a, (a == DAB_OFS_CONV) ? {d[7:1], 1'b0} : d};
    @(posedge clock);
    req <= '0;
    #1;
    q = rdata;
    v = rvalid;
  endtask
endmodule
`default_nettype wire

//--- bench/dab_regs_tb.sv
`default_nettype none
module dab_regs_tb
  import dab_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock;
  logic       rst_n;
  dab_req_t   req;
  logic [7:0] rdata;
  logic       rvalid;
  dab_ctrl_t  ctrl;
  logic       soft_reset_pulse;
  int         error_cnt;
  int         tests_run;
  logic [7:0] q;
  logic       v;

  dab_regs DUT (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .ctrl(ctrl), .soft_reset_pulse(soft_reset_pulse));
  dab_host HOST (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h got %h", n, e, g);
    end
  endtask

  function automatic logic [7:0] flags();
    return {3'h0, ctrl.sync_low, ctrl.gain_control_disable, ctrl.clk_sleep,
            ctrl.luma_sleep, ctrl.chroma_sleep};
  endfunction

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic t_defaults();
    chk("clamp", DAB_CLAMP_L2, ctrl.clamp_level);
    chk("flags", 8'h01, flags());
    chk("burst", 8'h5d, ctrl.burst_gate_delay);
    HOST.xfer(1'b0, 1'b1, DAB_OFS_BURST, 8'h00, q, v);
    chk("rd_burst", 8'h5d, q);
    HOST.xfer(1'b0, 1'b1, DAB_OFS_CONV, 8'h00, q, v);
    chk("rd_conv", 8'h82, q);
  endtask

  task automatic t_fields();
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], i[0], ~i[0], i[1], i[0], ~i[1], 1'b0};
      HOST.xfer(1'b1, 1'b0, DAB_OFS_CONV, d, q, v);
      @(posedge clock);
      #1;
      chk("clamp", 8'h30 + {4'h0, i[1:0], 2'h0}, ctrl.clamp_level);
      chk("flags", {3'h0, d[5:1]}, flags());
      HOST.xfer(1'b0, 1'b1, DAB_OFS_CONV, 8'h00, q, v);
      chk("rd_conv", d, q);
    end
  endtask

  task automatic t_burst();
    HOST.xfer(1'b1, 1'b1, DAB_OFS_BURST, 8'd115, q, v);
    chk("pre_write", 8'h5d, q);
    chk("rvalid", 8'h01, {7'h0, v});
    HOST.xfer(1'b0, 1'b1, DAB_OFS_BURST, 8'h00, q, v);
    chk("post_write", 8'd115, q);
  endtask

  task automatic t_software_reset_cmd();
    HOST.xfer(1'b0, 1'b1, DAB_OFS_SOFTWARE_RESET_CMD, 8'h00, q, v);
    HOST.xfer(1'b0, 1'b1, DAB_OFS_RSV_LO, 8'h00, q, v);
    chk("rsv_rvalid", 8'h01, {7'h0, v});
    chk("no_pulse", 8'h00, {7'h0, soft_reset_pulse});
    HOST.xfer(1'b0, 1'b1, DAB_OFS_BURST, 8'h00, q, v);
    chk("kept_burst", 8'd115, q);
    HOST.xfer(1'b1, 1'b0, DAB_OFS_SOFTWARE_RESET_CMD, 8'ha6, q, v);
    chk("software_reset_cmd_pulse", 8'h01, {7'h0, soft_reset_pulse});
    @(posedge clock);
    #1;
    t_defaults();
  endtask

  initial
  begin
    rst_n = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    t_defaults();
    t_fields();
    t_burst();
    t_software_reset_cmd();
    end_of_test();
  end

  initial
  begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
